/* rtl/egress_vlan_tag_editor.sv */
`timescale 1ns/1ps
`include "egress_vlan_tag_editor_defs.svh"

module egress_vlan_tag_editor
  import egress_vlan_tag_editor_pkg::*;
#(
  parameter int CNT_W = 32
)(
  // Clock and reset
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // AHB-Lite slave
  input  wire logic                                  hsel,
  input  wire logic [31:0]                           haddr,
  input  wire logic [1:0]                            htrans,
  input  wire logic                                  hwrite,
  input  wire logic [31:0]                           hwdata,
  input  wire logic                                  hready,
  output logic      [31:0]                           hrdata,
  output logic                                       hreadyout,
  output logic                                       hresp,
  // Frames from the queues
  input  wire egress_vlan_tag_editor_pkg::pkt_byte_t in_byte,
  input  wire egress_vlan_tag_editor_pkg::pkt_info_t in_info,
  input  wire logic                                  in_valid,
  output logic                                       in_ready,
  // Frames to the transmit MAC
  output egress_vlan_tag_editor_pkg::pkt_byte_t      out_byte,
  output logic                                       out_valid,
  input  wire logic                                  out_ready,
  // Drop events per ingress port
  input  wire logic [2:0]                            buf_drop,
  input  wire logic [2:0]                            red_pkt,
  input  wire logic [2:0]                            yellow_drop,
  output logic      [2:0]                            rate_discard
);
  import egress_vlan_tag_editor_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] idx);
    return w[8*idx +: 8];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [`CFG_W-1:0]  buffer_manager_config_reg,     buffer_manager_config_next;
  port_cfg_t          egr_cfg_reg [3], egr_cfg_next [3];
  vid_pri_t           dflt_reg [3],    dflt_next [3];
  logic [CNT_W-1:0]   total_cnt_reg [3], total_cnt_next [3];
  logic [CNT_W-1:0]   rate_cnt_reg [3],  rate_cnt_next [3];
  logic [2:0]         rate_discard_reg, rate_discard_next;
  logic [2:0]         rate_hit;

  logic               wr_pend_reg,    wr_pend_next;
  logic               rd_pend_reg,    rd_pend_next;
  logic [7:0]         addr_reg,       addr_next;
  logic               addr_ok_reg,    addr_ok_next;
  logic [31:0]        hrdata_reg,     hrdata_next;
  logic               hreadyout_reg,  hreadyout_next;
  logic               take_addr;

  edit_state_t        state_reg,      state_next;
  logic [3:0]         cnt_reg,        cnt_next;
  logic [2:0]         held_reg,       held_next;
  logic               eop_seen_reg,   eop_seen_next;
  logic [31:0]        tag_reg,        tag_next;
  logic [31:0]        newtag_reg,     newtag_next;
  logic [31:0]        crc_reg,        crc_next;
  pkt_info_t          info_reg,       info_next;
  pkt_byte_t          out_reg,        out_next;
  logic               out_valid_reg,  out_valid_next;
  logic               in_ready_reg,   in_ready_next;

  // Decision terms
  logic               take;
  logic               decide;
  logic [31:0]        cap;
  pkt_kind_t          kind;
  port_cfg_t          pc;
  vid_pri_t           sel;
  logic               unt_d;
  logic               unt_v;

  assign hrdata       = hrdata_reg;
  assign hreadyout    = hreadyout_reg;
  assign hresp        = 1'b0 & hreadyout_reg;
  assign in_ready     = in_ready_reg;
  assign out_byte     = out_reg;
  assign out_valid    = out_valid_reg;
  assign rate_discard = rate_discard_reg;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == `OFS_BUF_MGR_CFG)
      r = 32'(buffer_manager_config_reg);
    if (a == `OFS_EGR_TAG_CFG)
    begin
      for (int i = 0; i < 3; i++)
        r[`EGR_LANE_W*i +: `EGR_FIELD_W] = egr_cfg_reg[i];
    end
    for (int i = 0; i < 3; i++)
    begin
      if (a == 8'(`OFS_DFLT_BASE + 4*i))
        r = 32'(dflt_reg[i]);
      if (a == 8'(`OFS_TDROP_BASE + 4*i))
        r = 32'(total_cnt_reg[i]);
      if (a == 8'(`OFS_RDROP_BASE + 4*i))
        r = 32'(rate_cnt_reg[i]);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign take_addr = hsel && hready && htrans[1];

  always_comb
  begin
    wr_pend_next   = take_addr && hwrite;
    rd_pend_next   = take_addr && !hwrite;
    addr_next      = take_addr ? haddr[7:0] : addr_reg;
    addr_ok_next   = take_addr ? (haddr[31:8] == 24'h000000) : addr_ok_reg;
    // Reads wait one cycle so that a write just ahead is visible
    hreadyout_next = rd_pend_reg || !(take_addr && !hwrite);
    hrdata_next    = hrdata_reg;
    if (rd_pend_reg)
      hrdata_next = addr_ok_reg ? reg_read(addr_reg) : 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      addr_reg      <= 8'h00;
      addr_ok_reg   <= 1'b0;
      hrdata_reg    <= 32'h00000000;
      hreadyout_reg <= 1'b1;
    end
    else
    begin
      wr_pend_reg   <= wr_pend_next;
      rd_pend_reg   <= rd_pend_next;
      addr_reg      <= addr_next;
      addr_ok_reg   <= addr_ok_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and drop counters
  // ----------------------------------------------------------------
  assign rate_hit = (red_pkt & {3{buffer_manager_config_reg[`CFG_DROP_RED_BIT]}})
                  | (yellow_drop & {3{buffer_manager_config_reg[`CFG_DROP_YEL_BIT]}});

  always_comb
  begin
    buffer_manager_config_next       = buffer_manager_config_reg;
    rate_discard_next = rate_hit;
    for (int i = 0; i < 3; i++)
    begin
      egr_cfg_next[i]   = egr_cfg_reg[i];
      dflt_next[i]      = dflt_reg[i];
      total_cnt_next[i] = total_cnt_reg[i] + CNT_W'(buf_drop[i]) + CNT_W'(rate_hit[i]);
      rate_cnt_next[i]  = rate_cnt_reg[i] + CNT_W'(rate_hit[i]);
    end
    if (wr_pend_reg && addr_ok_reg)
    begin
      if (addr_reg == `OFS_BUF_MGR_CFG)
        buffer_manager_config_next = hwdata[`CFG_W-1:0];
      for (int i = 0; i < 3; i++)
      begin
        if (addr_reg == `OFS_EGR_TAG_CFG)
          egr_cfg_next[i] = port_cfg_t'(hwdata[`EGR_LANE_W*i +: `EGR_FIELD_W]);
        if (addr_reg == 8'(`OFS_DFLT_BASE + 4*i))
          dflt_next[i] = hwdata[`DFLT_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      buffer_manager_config_reg       <= `RST_BUF_MGR_CFG;
      rate_discard_reg <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        egr_cfg_reg[i]   <= '0;
        dflt_reg[i]      <= `RST_DFLT;
        total_cnt_reg[i] <= '0;
        rate_cnt_reg[i]  <= '0;
      end
    end
    else
    begin
      buffer_manager_config_reg       <= buffer_manager_config_next;
      rate_discard_reg <= rate_discard_next;
      egr_cfg_reg      <= egr_cfg_next;
      dflt_reg         <= dflt_next;
      total_cnt_reg    <= total_cnt_next;
      rate_cnt_reg     <= rate_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Tag classification and selection
  // ----------------------------------------------------------------
  assign take   = in_valid && in_ready_reg;
  assign decide = (state_reg == ST_CAP) && (cnt_reg == `TAG_LAST) && take && !in_byte.eop;
  assign cap    = {tag_reg[23:0], in_byte.data};
  assign pc     = (info_reg.egress_port < 2'h3) ? egr_cfg_reg[info_reg.egress_port] : '0;
  assign unt_d  = info_reg.untag_dflt[info_reg.egress_port];
  assign unt_v  = info_reg.untag_vid[info_reg.egress_port];

  always_comb
  begin
    if (info_reg.host_special)
      kind = KIND_SPECIAL;
    else if (cap[31:16] == `TPID_8021Q)
      kind = (cap[11:0] == 12'h000) ? KIND_PRIO : KIND_NORMAL;
    else
      kind = KIND_UNTAG;
    if (pc.vid_pri_sel)
      sel = (info_reg.egress_port < 2'h3) ? dflt_reg[info_reg.egress_port] : '0;
    else
      sel = {info_reg.ingress_pri, dflt_reg[info_reg.ingress_port].vid};
  end

  // ----------------------------------------------------------------
  // Frame editor
  // ----------------------------------------------------------------
  always_comb
  begin
    logic      emit;
    logic      act_tag;
    logic      hold;
    logic [31:0] nt;
    pkt_byte_t eb;
    emit          = 1'b0;
    act_tag       = 1'b0;
    hold          = 1'b0;
    nt            = cap;
    eb            = '0;
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    held_next     = held_reg;
    eop_seen_next = eop_seen_reg;
    tag_next      = tag_reg;
    newtag_next   = newtag_reg;
    crc_next      = crc_reg;
    info_next     = info_reg;
    out_next      = out_reg;
    out_valid_next = out_valid_reg && !out_ready;

    // Edit decision, used on the fourth byte after the source address
    unique case (pc.ptype)
      PT_DUMB:
      begin
        hold    = (kind == KIND_UNTAG);
        act_tag = (kind == KIND_PRIO) || (kind == KIND_NORMAL);
      end
      PT_ACCESS:
        hold = (kind == KIND_UNTAG);
      PT_HOST:
      begin
        act_tag = 1'b1;
        hold    = (kind != KIND_SPECIAL);
        if (kind != KIND_SPECIAL)
          nt = {`SPECIAL_TPID, 14'h0000, info_reg.ingress_port};
      end
      PT_HYBRID:
      begin
        unique case (kind)
          KIND_UNTAG:
          begin
            hold    = 1'b1;
            act_tag = pc.insert_tag && !unt_d;
            nt      = {`TPID_8021Q, sel.pri, 1'b0, sel.vid};
          end
          KIND_PRIO:
          begin
            act_tag = !unt_d;
            nt      = {cap[31:16], pc.chg_pri ? sel.pri : cap[15:13], cap[12], sel.vid};
          end
          KIND_NORMAL:
          begin
            act_tag = !unt_v;
            if (pc.chg_tag && (pc.chg_vid || pc.chg_pri))
            begin
              if (pc.chg_vid)
                nt[11:0] = sel.vid;
              if (pc.chg_pri)
                nt[15:13] = sel.pri;
            end
          end
          KIND_SPECIAL:
            act_tag = 1'b0;
        endcase
      end
    endcase

    unique case (state_reg)
      ST_HDR:
        if (take)
        begin
          emit = 1'b1;
          eb   = '{data: in_byte.data, sop: (cnt_reg == 4'h0), eop: 1'b0};
          if (cnt_reg == 4'h0)
            info_next = in_info;
          cnt_next = cnt_reg + 4'h1;
          if (in_byte.eop)
          begin
            state_next = ST_FCS;
            cnt_next   = 4'h0;
          end
          else if (cnt_reg == `HDR_LAST)
          begin
            state_next = ST_CAP;
            cnt_next   = 4'h0;
          end
        end
      ST_CAP:
        if (take)
        begin
          tag_next = cap;
          cnt_next = cnt_reg + 4'h1;
          if (in_byte.eop)
          begin
            // Short frame: flush what was captured, no tag edit
            eop_seen_next = 1'b1;
            held_next     = 3'(cnt_reg + 4'h1);
            state_next    = ST_HELD;
            cnt_next      = 4'h0;
          end
          else if (decide)
          begin
            newtag_next = nt;
            held_next   = hold ? 3'h4 : 3'h0;
            cnt_next    = 4'h0;
            state_next  = act_tag ? ST_TAG : (hold ? ST_HELD : ST_BODY);
          end
        end
      ST_TAG:
        if (!out_valid_next)
        begin
          emit     = 1'b1;
          eb.data  = byte_of(newtag_reg, 2'(`TAG_LAST - cnt_reg));
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `TAG_LAST)
          begin
            cnt_next   = 4'h0;
            state_next = (held_reg != 3'h0) ? ST_HELD : ST_BODY;
          end
        end
      ST_HELD:
        if (!out_valid_next)
        begin
          emit      = 1'b1;
          eb.data   = byte_of(tag_reg, 2'(held_reg - 3'h1));
          held_next = held_reg - 3'h1;
          if (held_reg == 3'h1)
            state_next = eop_seen_reg ? ST_FCS : ST_BODY;
        end
      ST_BODY:
        if (take)
        begin
          emit = 1'b1;
          eb.data = in_byte.data;
          if (in_byte.eop)
            state_next = ST_FCS;
        end
      ST_FCS:
        if (!out_valid_next)
        begin
          emit     = 1'b1;
          eb.data  = ~byte_of(crc_reg, cnt_reg[1:0]);
          eb.eop   = (cnt_reg == `TAG_LAST);
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `TAG_LAST)
          begin
            cnt_next      = 4'h0;
            eop_seen_next = 1'b0;
            state_next    = ST_HDR;
          end
        end
    endcase

    if (emit)
    begin
      out_next       = eb;
      out_valid_next = 1'b1;
      if (state_reg != ST_FCS)
        crc_next = crc_step(eb.sop ? `CRC_INIT : crc_reg, eb.data);
    end
    in_ready_next = (state_next == ST_CAP)
                  || (((state_next == ST_HDR) || (state_next == ST_BODY)) && !out_valid_next);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg     <= ST_HDR;
      cnt_reg       <= 4'h0;
      held_reg      <= 3'h0;
      eop_seen_reg  <= 1'b0;
      tag_reg       <= 32'h00000000;
      newtag_reg    <= 32'h00000000;
      crc_reg       <= `CRC_INIT;
      info_reg      <= '0;
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
      in_ready_reg  <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      held_reg      <= held_next;
      eop_seen_reg  <= eop_seen_next;
      tag_reg       <= tag_next;
      newtag_reg    <= newtag_next;
      crc_reg       <= crc_next;
      info_reg      <= info_next;
      out_reg       <= out_next;
      out_valid_reg <= out_valid_next;
      in_ready_reg  <= in_ready_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait:    assert property (take_addr && !hwrite |=> !hreadyout_reg ##1 hreadyout_reg)
                  else $error("read wait state wrong");
  a_red_both:     assert property (red_pkt[0] && buffer_manager_config_reg[`CFG_DROP_RED_BIT] && !buf_drop[0]
                  |=> rate_cnt_reg[0] == $past(rate_cnt_reg[0]) + 1'b1
                      && total_cnt_reg[0] == $past(total_cnt_reg[0]) + 1'b1)
                  else $error("red drop not counted in both");
  a_red_discard:  assert property (red_pkt[2] && buffer_manager_config_reg[`CFG_DROP_RED_BIT] |=> rate_discard_reg[2])
                  else $error("red frame not discarded");
  a_total_only:   assert property (buf_drop[1] && !rate_hit[1]
                  |=> total_cnt_reg[1] == $past(total_cnt_reg[1]) + 1'b1 && $stable(rate_cnt_reg[1]))
                  else $error("buffer drop count wrong");
  a_access_strip: assert property (decide && pc.ptype == PT_ACCESS && kind != KIND_UNTAG
                  |=> state_reg == ST_BODY)
                  else $error("access port kept a tag");
  a_dumb_pass:    assert property (decide && pc.ptype == PT_DUMB && (kind == KIND_PRIO || kind == KIND_NORMAL)
                  |=> state_reg == ST_TAG && newtag_reg == $past(cap))
                  else $error("dumb port altered a tag");
  a_special_drop: assert property (decide && kind == KIND_SPECIAL && pc.ptype != PT_HOST
                  |=> state_reg == ST_BODY)
                  else $error("special tag not stripped");
  a_hybrid_ins:   assert property (decide && pc.ptype == PT_HYBRID && kind == KIND_UNTAG && pc.insert_tag && !unt_d
                  |=> state_reg == ST_TAG && newtag_reg[31:16] == `TPID_8021Q ##[4:64] state_reg == ST_HELD)
                  else $error("hybrid insert wrong");
  a_keep_pri:     assert property (decide && pc.ptype == PT_HYBRID && kind == KIND_PRIO && !unt_d && !pc.chg_pri
                  |=> newtag_reg[15:13] == $past(cap[15:13]))
                  else $error("priority changed without control");
  a_normal_keep:  assert property (decide && pc.ptype == PT_HYBRID && kind == KIND_NORMAL && !unt_v
                  && !pc.chg_vid && !pc.chg_pri |=> newtag_reg == $past(cap))
                  else $error("normal tag modified");

endmodule // egress_vlan_tag_editor

/* rtl/egress_vlan_tag_editor_defs.svh */
`ifndef EGRESS_VLAN_TAG_EDITOR_DEFS_SVH
`define EGRESS_VLAN_TAG_EDITOR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_BUF_MGR_CFG   8'h00
`define OFS_EGR_TAG_CFG   8'h04
`define OFS_DFLT_BASE     8'h08
`define OFS_TDROP_BASE    8'h14
`define OFS_RDROP_BASE    8'h20

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CFG_W             2
`define CFG_DROP_RED_BIT  0
`define CFG_DROP_YEL_BIT  1
`define EGR_LANE_W        8
`define EGR_FIELD_W       7
`define DFLT_W            15
`define RST_BUF_MGR_CFG   2'h0
`define RST_DFLT          15'h0001

// ----------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------
`define TPID_8021Q        16'h8100
`define SPECIAL_TPID      16'h9100
`define HDR_LAST          4'hB
`define TAG_LAST          4'h3
`define CRC_INIT          32'hFFFFFFFF
`define CRC_POLY          32'hEDB88320

`endif

/* rtl/egress_vlan_tag_editor_pkg.sv */
package egress_vlan_tag_editor_pkg;

  typedef enum logic [1:0] {PT_DUMB, PT_ACCESS, PT_HYBRID, PT_HOST} port_type_t;
  typedef enum logic [1:0] {KIND_UNTAG, KIND_PRIO, KIND_NORMAL, KIND_SPECIAL} pkt_kind_t;

  typedef struct packed {
    logic       chg_pri;
    logic       chg_vid;
    logic       chg_tag;
    logic       vid_pri_sel;
    logic       insert_tag;
    port_type_t ptype;
  } port_cfg_t;

  typedef struct packed {
    logic [2:0]  pri;
    logic [11:0] vid;
  } vid_pri_t;

  typedef struct packed {
    logic [1:0] ingress_port;
    logic [1:0] egress_port;
    logic [2:0] ingress_pri;
    logic [2:0] untag_dflt;
    logic [2:0] untag_vid;
    logic       host_special;
  } pkt_info_t;

  typedef struct packed {
    logic [7:0] data;
    logic       sop;
    logic       eop;
  } pkt_byte_t;

  typedef enum {ST_HDR, ST_CAP, ST_TAG, ST_HELD, ST_BODY, ST_FCS} edit_state_t;

endpackage

/* bench/tx_mac_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Transmit MAC side, stalls at random
// ----------------------------------------
module tx_mac_model (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Accept toward the editor
  output logic      out_ready
);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_ready <= 1'b0;
    else
      out_ready <= ($urandom % 4) != 0;
  end
endmodule // tx_mac_model

/* bench/egress_vlan_tag_editor_tb.sv */
`timescale 1ns/1ps
`include "egress_vlan_tag_editor_defs.svh"
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end

module egress_vlan_tag_editor_tb;
  import egress_vlan_tag_editor_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, in_valid = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, in_ready, out_valid, out_ready;
  logic [2:0]  buf_drop = 0, red_pkt = 0, rate_discard, yellow_drop = 0;
  pkt_byte_t   in_byte = '0, out_byte, e;
  pkt_info_t   in_info = '0;
  pkt_byte_t   exq[$];
  logic [7:0]  q[$];
  int          n_mismatch = 0, compares = 0, cyc = 0;
  logic [31:0] cf[11] = '{32'h0, 32'h100, 32'hE00, 32'h3A00, 32'h3A00, 32'h1200, 32'h4A00, 32'hA00, 32'hA00,
                          32'h3200, 32'h300};
  logic [31:0] ti[11] = '{32'h81002005, 32'h81002005, 32'h08004500, 32'h81006005, 32'h81006005, 32'h81006005,
                          32'h81002000, 32'h81002000, 32'h81002000, 32'h81006005, 32'h08004500};
  logic [31:0] to[11] = '{32'h0, 32'h0, 32'h8100A123, 32'h81006123, 32'h0, 32'h0, 32'h8100A123, 32'h81002123,
                          32'h0, 32'h81006001, 32'h91000000};
  logic [1:0]  md[11] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h3, 2'h3, 2'h1, 2'h3, 2'h2};
  logic [2:0]  uv[11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0};

  egress_vlan_tag_editor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .in_byte(in_byte), .in_info(in_info), .in_valid(in_valid), .in_ready(in_ready),
    .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready), .buf_drop(buf_drop),
    .red_pkt(red_pkt), .yellow_drop(yellow_drop), .rate_discard(rate_discard));
  tx_mac_model mac (.hclk(hclk), .hresetn(hresetn), .out_ready(out_ready));

  initial forever #2 hclk = ~hclk;

  // ----------------------------------------
  // Timeout and output scoreboard
  // ----------------------------------------
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
    if (out_valid && out_ready)
    begin
      e = exq.pop_front();
      `CHK("out_byte", e, out_byte)
    end
  end

  function automatic logic [31:0] crc(input logic [7:0] d[$]);
    logic [31:0] c;
    c = `CRC_INIT;
    foreach (d[i])
    begin
      c ^= {24'h0, d[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction

  task automatic wt(output logic [31:0] d);
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    d = hrdata;
    @(posedge hclk);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt(r);
    htrans <= 2'h0;
    hwdata <= d;
    wt(r);
  endtask

  task automatic frame(input logic [2:0] u, input logic [31:0] tin, input logic [1:0] m, input logic [31:0] tou);
    logic [7:0]  b[20];
    logic [31:0] c;
    for (int i = 0; i < 20; i++) b[i] = 8'($urandom);
    {b[12], b[13], b[14], b[15]} = tin;
    q = {};
    for (int i = 0; i < 12; i++) q.push_back(b[i]);
    if (m >= 2) for (int k = 0; k < 4; k++) q.push_back(tou[31 - 8 * k -: 8]);
    if (m == 0 || m == 2) for (int i = 12; i < 16; i++) q.push_back(b[i]);
    for (int i = 16; i < 20; i++) q.push_back(b[i]);
    c = crc(q);
    foreach (q[i]) exq.push_back('{q[i], i == 0, 1'b0});
    for (int k = 0; k < 4; k++) exq.push_back('{c[8 * k +: 8], 1'b0, k == 3});
    @(posedge hclk);
    in_info <= '{2'h0, 2'h1, 3'($urandom), u, u, 1'b0};
    for (int i = 0; i < 20; i++)
    begin
      in_byte  <= '{b[i], i == 0, i == 19};
      in_valid <= 1'b1;
      @(negedge hclk);
      while (in_ready !== 1'b1) @(negedge hclk);
      @(posedge hclk);
    end
    in_valid <= 1'b0;
    while (exq.size() != 0) @(posedge hclk);
  endtask

  task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    r = $urandom(71);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 8'h08, 32'h0);
    `CHK("default_vid", 32'h1, r)
    ahb(1'b0, 8'hFC, 32'h0);
    `CHK("unmapped", 32'h0, r)
    `CHK("hresp", 1'b0, hresp)
    ahb(1'b1, 8'h0C, 32'h5123);
    for (int i = 0; i < 11; i++)
    begin
      ahb(1'b1, 8'h04, cf[i]);
      frame(uv[i], ti[i], md[i], to[i]);
    end
    ahb(1'b1, 8'h00, 32'h3);
    red_pkt     <= 3'h5;
    buf_drop    <= 3'h6;
    @(posedge hclk);
    red_pkt     <= 3'h0;
    buf_drop    <= 3'h0;
    yellow_drop <= 3'h2;
    @(negedge hclk);
    `CHK("rate_discard", 3'h5, rate_discard)
    @(posedge hclk);
    yellow_drop <= 3'h0;
    @(negedge hclk);
    `CHK("rate_discard", 3'h2, rate_discard)
    ahb(1'b1, 8'h28, 32'h5);
    ahb(1'b0, 8'h1C, 32'h0);
    `CHK("total_drop", 32'h2, r)
    ahb(1'b0, 8'h28, 32'h0);
    `CHK("rate_drop", 32'h1, r)
    ahb(1'b0, 8'h18, 32'h0);
    `CHK("total_drop", 32'h2, r)
    ahb(1'b0, 8'h24, 32'h0);
    `CHK("rate_drop", 32'h1, r)
    ahb(1'b0, 8'h14, 32'h0);
    `CHK("total_drop", 32'h1, r)
    wrap_up();
  end
endmodule // egress_vlan_tag_editor_tb
